// *** design/adc_pkg.sv ***
package adc_pkg;
    localparam int unsigned APB_AW = 8;
    localparam int unsigned RESULT_W = 8;
    // Register indices; byte offset is four times the index
    localparam logic [APB_AW-1:0] IDX_RESULT = 8'h1D;
    localparam logic [APB_AW-1:0] IDX_CTRL = 8'h1E;
    localparam logic [APB_AW-1:0] OFS_RESULT = 8'(IDX_RESULT * 4);
    localparam logic [APB_AW-1:0] OFS_CTRL = 8'(IDX_CTRL * 4);
    // Field positions in converter_status_control
    localparam int unsigned DONE_BIT = 7;
    localparam int unsigned RC_BIT = 6;
    localparam int unsigned ON_BIT = 5;
    localparam int unsigned SEL_LSB = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [RESULT_W-1:0] RESULT_RESET = 8'h00;
    localparam logic [RESULT_W-1:0] DAC_MID = 8'h80;
    // One conversion spans 32 conversion clocks, four per result bit
    localparam int unsigned CONV_CYCLES = 32;
    localparam int unsigned STEP_CYCLES = CONV_CYCLES / RESULT_W;
    localparam logic [4:0] CNT_LAST = 5'(CONV_CYCLES - 1);
    localparam logic [1:0] STEP_LAST = 2'(STEP_CYCLES - 1);
    // Select code 0 maps to port pin 6, code 3 to pin 3
    localparam int unsigned FIRST_PIN = 6;
    localparam int unsigned PORT_W = 8;

    typedef struct packed {
        logic rc_clock_select;
        logic converter_on;
        logic [1:0] input_select_field;
    } ctrl_t;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_CONV = 1'b1
    } conv_state_t;
endpackage : adc_pkg

// *** design/adc_sar_control.sv ***
// How it works
// (RULE1) Four inputs, one 8-bit unsigned result each
// (RULE2) Successive approximation, MSB first, via comparator
// (RULE3) Full scale gives FF, ground gives 00
// (RULE4) Conversion lasts 32 conversion clock cycles
// (RULE5) Clock select: 1 RC oscillator, 0 bus
// (RULE6) Results handed over on the bus clock
// (RULE7) Done flag bit 7 set on completion
// (RULE8) Done flag cleared by start or access
// (RULE9) Register access starts conversion, overwrites result
// (RULE10) Bit 5 enables the converter
// (RULE11) Select 00..11 picks port pins 6..3
// (RULE12) Selected analog pin reads zero digitally
// (RULE13) Other port pins stay normal digital inputs
// (RULE14) Result register updated when flag sets
// (RULE15) Wait mode does not stop conversions
// (RULE16) Stop mode powers down and aborts conversion
// (RULE17) No extra settling wait after stop
// (RULE18) Control bits 4 to 2 read zero
// (RULE19) Software picks RC clock below 1 MHz
// (RULE20) Software polls flag when on RC clock
// (RULE21) Software distrusts results while stabilising
// (RULE22) Disabled converter ignores starts, flag clear
`timescale 1ns/1ps
`default_nettype none
module adc_sar_control
    import adc_pkg::*;
(
    input wire logic pclk,                    // Bus clock, 200 MHz
    input wire logic presetn,                 // Async reset, active low
    input wire logic psel,                    // APB select
    input wire logic penable,                 // APB enable
    input wire logic pwrite,                  // APB direction
    input wire logic [APB_AW-1:0] paddr,      // APB byte address
    input wire logic [31:0] pwdata,           // APB write data
    output logic [31:0] prdata,               // APB read data
    output logic pready,                      // APB ready
    output logic pslverr,                     // APB error, unmapped
    input wire logic rc_tick,                 // RC oscillator clock tick
    input wire logic comp_above,              // Input at or above DAC
    input wire logic stop_mode,               // Device in stop mode
    input wire logic [PORT_W-1:0] portc_pins, // Port C pin levels
    output logic [RESULT_W-1:0] dac_code,     // Trial code to DAC
    output logic [1:0] input_select,          // Analog mux select
    output logic analog_power_on,             // Comparator, charge pump
    output logic [PORT_W-1:0] portc_read      // Port C digital read
);

    ctrl_t ctrl_q;
    conv_state_t state_q;
    logic done_q;
    logic [4:0] cnt_q;
    logic [RESULT_W-1:0] sar_q;
    logic [RESULT_W-1:0] result_q;
    logic [RESULT_W-1:0] dac_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic power_q;
    logic [PORT_W-1:0] portc_q;

    logic access;
    logic hit;
    logic ctrl_wr;
    logic new_on;
    logic start;
    logic abort;
    logic tick;
    logic step;
    logic finish;
    logic [2:0] bitpos;
    logic [RESULT_W-1:0] sar_next;
    logic [RESULT_W-1:0] trial_next;
    logic [31:0] rd_word;
    logic mapped;

    assign access = psel & penable & pready_q;
    assign mapped = (paddr == OFS_CTRL) || (paddr == OFS_RESULT);
    assign hit = access & mapped;
    assign ctrl_wr = access & pwrite & (paddr == OFS_CTRL);
    assign new_on = ctrl_wr ? pwdata[ON_BIT] : ctrl_q.converter_on;
    // Either register, read or write, launches a new conversion
    assign start = hit & new_on & ~stop_mode; // [RULE9] [RULE22]
    assign abort = stop_mode | (ctrl_wr & ~pwdata[ON_BIT]); // [RULE16]
    // Wait mode gates nothing here, so conversions keep running
    assign tick = ctrl_q.rc_clock_select ? rc_tick : 1'b1; // [RULE5] [RULE15]
    assign step = (state_q == ST_CONV) & tick & ~abort & ~hit;
    assign finish = step & (cnt_q == CNT_LAST); // [RULE4]
    assign bitpos = 3'(RESULT_W - 1) - cnt_q[4:2];

    // One result bit per four steps, most significant first
    always_comb begin
        sar_next = sar_q;
        // Between decisions the current trial code stays on the DAC
        trial_next = dac_q;
        if (cnt_q[1:0] == STEP_LAST) begin
            sar_next[bitpos] = comp_above; // [RULE2] [RULE3]
            trial_next = sar_next;
            if (bitpos != 3'd0) begin
                trial_next[bitpos - 3'd1] = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= ctrl_t'(4'h0);
        end else if (ctrl_wr) begin
            ctrl_q.rc_clock_select <= pwdata[RC_BIT]; // [RULE5]
            ctrl_q.converter_on <= pwdata[ON_BIT]; // [RULE10]
            ctrl_q.input_select_field <= pwdata[SEL_LSB +: 2]; // [RULE11]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_IDLE;
            cnt_q <= 5'h00;
        end else if (start) begin
            state_q <= ST_CONV;
            cnt_q <= 5'h00;
        end else if (abort || finish) begin
            state_q <= ST_IDLE;
            cnt_q <= 5'h00;
        end else if (step) begin
            cnt_q <= cnt_q + 5'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sar_q <= RESULT_RESET;
            dac_q <= RESULT_RESET;
        end else if (start) begin
            sar_q <= RESULT_RESET;
            dac_q <= DAC_MID; // [RULE2]
        end else if (step) begin
            sar_q <= sar_next;
            dac_q <= trial_next;
        end
    end

    // Result moves over on the bus clock, one channel at most per cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_q <= RESULT_RESET;
        end else if (finish) begin
            result_q <= sar_next; // [RULE1] [RULE6] [RULE14]
        end
    end

    // Access or a new start clears the flag even on a finishing edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_q <= 1'b0;
        end else if (hit || abort) begin
            done_q <= 1'b0; // [RULE8] [RULE22]
        end else if (finish) begin
            done_q <= 1'b1; // [RULE7]
        end
    end

    // Stop removes power on the next clock edge; leaving stop needs no settle delay
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_q <= 1'b0;
        end else begin
            power_q <= new_on & ~stop_mode; // [RULE16] [RULE17]
        end
    end

    generate
        for (genvar i = 0; i < PORT_W; i++) begin : g_port
            localparam logic [1:0] SEL_CODE = 2'((FIRST_PIN - i) & 3);
            localparam bit IS_ANALOG =
                (i <= FIRST_PIN) && (i >= FIRST_PIN - 3);
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    portc_q[i] <= 1'b0;
                end else if (IS_ANALOG && ctrl_q.converter_on &&
                             ctrl_q.input_select_field == SEL_CODE) begin
                    portc_q[i] <= 1'b0; // [RULE12]
                end else begin
                    portc_q[i] <= portc_pins[i]; // [RULE13]
                end
            end
        end
    endgenerate

    always_comb begin
        rd_word = 32'h0000_0000;
        if (paddr == OFS_CTRL) begin
            rd_word[DONE_BIT] = done_q;
            rd_word[RC_BIT] = ctrl_q.rc_clock_select;
            rd_word[ON_BIT] = ctrl_q.converter_on;
            rd_word[SEL_LSB +: 2] = ctrl_q.input_select_field; // [RULE18]
        end else if (paddr == OFS_RESULT) begin
            rd_word[RESULT_W-1:0] = result_q;
        end
    end

    // Read data and error are prepared in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
            pready_q <= 1'b0;
        end else begin
            pready_q <= 1'b1;
            if (psel && !penable) begin
                prdata_q <= pwrite ? 32'h0000_0000 : rd_word;
                pslverr_q <= ~mapped;
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign dac_code = dac_q;
    assign input_select = ctrl_q.input_select_field;
    assign analog_power_on = power_q;
    assign portc_read = portc_q;

    // Checks
    logic [4:0] ticks_seen_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ticks_seen_q <= 5'h00;
        end else if (start) begin
            ticks_seen_q <= 5'h00;
        end else if (step) begin
            ticks_seen_q <= ticks_seen_q + 5'h01;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_finish;
        finish && !hit;
    endsequence

    sequence s_start;
        hit && new_on && !stop_mode;
    endsequence

    sequence s_decide;
        step && cnt_q[1:0] == STEP_LAST;
    endsequence

    property p_done_set;
        s_finish |=> done_q;
    endproperty
    a_done_set: assert property (p_done_set) // [RULE7]
        else $error("flag not set after completion");

    property p_result_load;
        s_finish |=> result_q == $past(sar_next);
    endproperty
    a_result_load: assert property (p_result_load) // [RULE14]
        else $error("result not loaded on completion");

    property p_access_clear;
        hit |=> !done_q;
    endproperty
    a_access_clear: assert property (p_access_clear) // [RULE8]
        else $error("flag not cleared by access");

    property p_access_start;
        s_start |=> state_q == ST_CONV && cnt_q == 5'h00 && dac_q == DAC_MID;
    endproperty
    a_access_start: assert property (p_access_start) // [RULE9]
        else $error("access did not start conversion");

    property p_disabled;
        !ctrl_q.converter_on |-> state_q == ST_IDLE && !done_q;
    endproperty
    a_disabled: assert property (p_disabled) // [RULE22]
        else $error("disabled converter active");

    property p_thirty_two;
        s_finish |-> ticks_seen_q == CNT_LAST;
    endproperty
    a_thirty_two: assert property (p_thirty_two) // [RULE4]
        else $error("conversion length not 32 clocks");

    property p_bus_clock_len;
        s_start ##1 (!hit && !stop_mode && !ctrl_q.rc_clock_select)[*8]
            |=> cnt_q == 5'h08;
    endproperty
    a_bus_clock_len: assert property (p_bus_clock_len) // [RULE5]
        else $error("bus clock does not advance conversion");

    property p_stop_abort;
        stop_mode |=> state_q == ST_IDLE && !analog_power_on && !done_q;
    endproperty
    a_stop_abort: assert property (p_stop_abort) // [RULE16]
        else $error("stop did not abort conversion");

    property p_reserved_zero;
        psel && !penable && !pwrite && paddr == OFS_CTRL
            |=> prdata_q[31:8] == 24'h000000 && prdata_q[4:2] == 3'b000;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) // [RULE18]
        else $error("unused control bits not zero");

    property p_pin_zero;
        ctrl_q.converter_on
            |=> portc_read[FIRST_PIN - $past(ctrl_q.input_select_field)]
                == 1'b0;
    endproperty
    a_pin_zero: assert property (p_pin_zero) // [RULE12]
        else $error("selected analog pin reads one");

    property p_rc_hold;
        state_q == ST_CONV && ctrl_q.rc_clock_select && !rc_tick && !hit
            && !stop_mode |=> $stable(cnt_q);
    endproperty
    a_rc_hold: assert property (p_rc_hold) // [RULE5]
        else $error("conversion advanced without an oscillator tick");

    property p_trial_hold;
        step && cnt_q[1:0] != STEP_LAST |=> $stable(dac_q);
    endproperty
    a_trial_hold: assert property (p_trial_hold) // [RULE2]
        else $error("trial code changed between decisions");

    property p_decide_bit;
        s_decide |=> sar_q[$past(bitpos)] == $past(comp_above);
    endproperty
    a_decide_bit: assert property (p_decide_bit) // [RULE2]
        else $error("result bit does not follow comparator");

    property p_result_hold;
        !finish |=> $stable(result_q);
    endproperty
    a_result_hold: assert property (p_result_hold) // [RULE14]
        else $error("result changed without a completion");

    property p_other_pins;
        1'b1 |=> portc_read[2:0] == $past(portc_pins[2:0])
            && portc_read[PORT_W-1] == $past(portc_pins[PORT_W-1]);
    endproperty
    a_other_pins: assert property (p_other_pins) // [RULE13]
        else $error("digital pin outside analog group disturbed");

    property p_done_rose;
        $rose(done_q) |-> $past(finish);
    endproperty
    a_done_rose: assert property (p_done_rose) // [RULE7]
        else $error("flag set without a completion");

    property p_wake_power;
        $fell(stop_mode) && new_on |=> analog_power_on;
    endproperty
    a_wake_power: assert property (p_wake_power) // [RULE17]
        else $error("analog power late after leaving stop");

    property p_select_out;
        ctrl_wr |=> input_select == $past(pwdata[SEL_LSB +: 2]);
    endproperty
    a_select_out: assert property (p_select_out) // [RULE11]
        else $error("mux select does not follow written field");

    property p_enable_bit;
        ctrl_wr |=> ctrl_q.converter_on == $past(pwdata[ON_BIT]);
    endproperty
    a_enable_bit: assert property (p_enable_bit) // [RULE10]
        else $error("enable bit does not follow write");

    property p_off_abort;
        ctrl_wr && !pwdata[ON_BIT]
            |=> state_q == ST_IDLE && !done_q && !analog_power_on;
    endproperty
    a_off_abort: assert property (p_off_abort) // [RULE22]
        else $error("disable write left converter active");

endmodule : adc_sar_control
`default_nettype wire

// *** tb/analog_source_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module analog_source_model
    import adc_pkg::*;
(
    input wire logic [RESULT_W-1:0] dac_code, // Trial code
    input wire logic [1:0] input_select, // Mux select
    input wire logic analog_power_on, // Comparator powered
    input wire logic [31:0] levels, // Four input levels
    output logic comp_above // Input at or above trial
);
    logic [7:0] lvl;
    assign lvl = levels[input_select*8 +: 8];
    // Unpowered comparator gives no steady answer
    assign comp_above = analog_power_on ? (lvl >= dac_code)
        : ~dac_code[0];
endmodule : analog_source_model
`default_nettype wire

// *** tb/adc_sar_control_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module adc_sar_control_test;
    import adc_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic rc_tick = 0, stop_mode = 0, rc_run = 0, err;
    logic [APB_AW-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, levels = '0, rd;
    logic pready, pslverr, comp_above, analog_power_on;
    logic [PORT_W-1:0] portc_pins = '0, portc_read;
    logic [RESULT_W-1:0] dac_code;
    logic [1:0] input_select;
    int fail_count = 0, n_compared = 0, cyc = 0;

    adc_sar_control i_adc_sar_control (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rc_tick(rc_tick), .comp_above(comp_above),
        .stop_mode(stop_mode), .portc_pins(portc_pins),
        .dac_code(dac_code), .input_select(input_select),
        .analog_power_on(analog_power_on), .portc_read(portc_read));
    analog_source_model i_analog_source_model (.dac_code(dac_code),
        .input_select(input_select), .analog_power_on(analog_power_on),
        .levels(levels), .comp_above(comp_above));

    initial forever #2.5 pclk = ~pclk;

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        rc_tick <= rc_run && (cyc % 4 == 0);
        if (cyc == 20000) begin
            fail_count++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : stop_test

    task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask : chk

    task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb

    // Ideal successive approximation against a perfect comparator
    function automatic logic [7:0] sar(logic [7:0] l);
        logic [7:0] r = 8'h00;
        for (int b = 7; b >= 0; b--)
            if (l >= (r | (8'h01 << b))) r = r | (8'h01 << b);
        return r;
    endfunction : sar

    task automatic run(logic rc, logic [1:0] s, logic [7:0] l, int w);
        logic [7:0] pins = 8'($urandom);
        levels[s*8 +: 8] <= l;
        rc_run <= rc;
        apb(1, OFS_CTRL, {25'h0, rc, 4'h8, s});
        portc_pins <= pins;
        repeat (2) @(posedge pclk);
        chk("input_select", 32'(s), 32'(input_select));
        chk("dac_code", 32'(DAC_MID), 32'(dac_code));
        chk("power", 1, 32'(analog_power_on));
        chk("portc_read", 32'(pins & ~(8'h01 << (FIRST_PIN - s))),
            32'(portc_read));
        // First conversion after enabling is not trusted, only polled
        repeat (24) @(posedge pclk);
        apb(0, OFS_CTRL, 0);
        chk("early flag", {25'h0, rc, 4'h8, s}, rd);
        repeat (w) @(posedge pclk);
        apb(0, OFS_CTRL, 0);
        chk("done flag", {24'h0, 1'b1, rc, 4'h8, s}, rd);
        apb(0, OFS_RESULT, 0);
        chk("result", 32'(sar(l)), rd);
    endtask : run

    initial begin
        void'($urandom(46));
        repeat (8) @(posedge pclk);
        presetn <= 1;
        apb(0, OFS_CTRL, 0);
        chk("ctrl reset", 32'(CTRL_RESET), rd);
        apb(1, OFS_CTRL, 32'h0000009F);
        repeat (40) @(posedge pclk);
        apb(0, OFS_CTRL, 0);
        chk("ctrl bits", 32'h03, rd);
        apb(0, 8'h00, 0);
        chk("pslverr", 1, 32'(err));
        $display("register test finished");
        for (int i = 0; i < 8; i++)
            run(i[2], i[1:0], i == 0 ? 8'hFF : i == 1 ? 8'h00 : 8'($urandom),
                i[2] ? 150 : 36);
        $display("conversion test finished");
        rc_run <= 0;
        apb(1, OFS_CTRL, 32'h20);
        repeat (5) @(posedge pclk);
        stop_mode <= 1;
        repeat (3) @(posedge pclk);
        chk("stop power", 0, 32'(analog_power_on));
        repeat (40) @(posedge pclk);
        apb(0, OFS_CTRL, 0);
        chk("stop flag", 32'h20, rd);
        stop_mode <= 0;
        repeat (3) @(posedge pclk);
        chk("wake power", 1, 32'(analog_power_on));
        $display("stop test finished");
        stop_test();
    end
endmodule : adc_sar_control_test
`default_nettype wire
